// [verilog/adc_ctrl_defs.vh]
// Purpose: Constants for the converter control block
// Assumes: Register port with one-cycle read latency
// Notes: Offsets are register indices on the plain register port
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH
// Register offsets
`define ADDR_W 2
`define OFF_SELECT 2'h0
`define OFF_CONTROL 2'h1
`define OFF_RES_LOW 2'h2
`define OFF_RES_HIGH 2'h3
// Reset values
`define SELECT_RST 8'h00
`define CONTROL_RST 8'h00
// Select register fields
`define SEL_REF_HI 7
`define SEL_REF_LO 6
`define SEL_LEFT 5
`define SEL_CH_HI 3
`define SEL_CH_LO 0
`define SEL_WMASK 8'hEF
// Control register fields
`define CTL_EN 7
`define CTL_START 6
`define CTL_FREE 5
`define CTL_FLAG 4
`define CTL_IE 3
`define CTL_PS_HI 2
`define CTL_PS_LO 0
// Conversion timing in converter clocks
`define CYC_FIRST 5'h19
`define CYC_NORMAL 5'h0D
`define SAMPLE_FIRST 5'h0D
`define SAMPLE_NORMAL 5'h01
`define SAR_STEPS 5'h0A
`define RES_W 10
`define RES_TOP 10'h3FF
`endif

// [verilog/adc_prescaler.v]
// Purpose: Converter clock tick generator
// Assumes: Runs from system clock, cleared while converter is off
// Notes: Tick is one system cycle wide, once per divided period
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"
module adc_prescaler (
	input wire i_clk,
	input wire i_sys_rst,
	input wire i_run,
	input wire [2:0] i_select,
	output wire o_tick
);
	reg [6:0] count_q; // Free counter
	reg [6:0] mask; // Divisor minus one
	// Divisor table: codes 0 and 1 both give 2
	always @* begin
		case (i_select)
			3'h0: mask = 7'h01;
			3'h1: mask = 7'h01;
			3'h2: mask = 7'h03;
			3'h3: mask = 7'h07;
			3'h4: mask = 7'h0F;
			3'h5: mask = 7'h1F;
			3'h6: mask = 7'h3F;
			default: mask = 7'h7F;
		endcase
	end
	// Counter held at zero while stopped so the first tick is repeatable
	always @(posedge i_clk) begin
		if (i_sys_rst || !i_run) begin
			count_q <= 7'h00;
		end else begin
			count_q <= count_q + 7'h01;
		end
	end
	assign o_tick = i_run && ((count_q & mask) == mask);
endmodule

// [verilog/adc_conversion_control.v]
// Purpose: Control logic of a 10-bit successive-approximation converter
// Assumes: Analog core compares the DAC trial against the held input
// Notes: Registers sit on a plain port, read data one cycle after strobe
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"
module adc_conversion_control (
	input wire i_clk,
	input wire i_sys_rst,
	input wire [1:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire i_global_int_enable,
	input wire i_vector_ack,
	input wire i_compare,
	output wire o_irq,
	output reg o_power_on,
	output reg [1:0] o_reference,
	output reg [3:0] o_channel,
	output reg o_sample,
	output reg [9:0] o_trial
);
	// One-hot conversion states
	// Idle waits for start and a converter clock; done lasts one system cycle
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_CONV = 3'b010;
	localparam [2:0] S_DONE = 3'b100;
	reg [2:0] state_q; // Conversion state
	reg [7:0] select_q; // Software copy of selection register
	reg enable_q; // Converter on
	reg start_q; // Start bit, reads busy
	reg free_q; // Free-running mode
	reg flag_q; // Completion flag
	reg ie_q; // Completion interrupt enable
	reg [2:0] ps_q; // Prescaler code
	reg first_q; // Next conversion is the initialising one
	reg [4:0] cyc_q; // Converter clocks into the conversion
	reg [9:0] sar_q; // Approximation register
	reg [9:0] result_q; // Published result
	reg [9:0] pending_q; // Result held back while locked
	reg pend_valid_q; // A held-back result waits
	reg lock_q; // Low byte read, high not yet
	wire tick; // Converter clock edge
	// Register port decodes; only the result reads have a side effect
	wire wr_sel = i_wr && (i_addr == `OFF_SELECT);
	wire wr_ctl = i_wr && (i_addr == `OFF_CONTROL);
	wire rd_low = i_rd && (i_addr == `OFF_RES_LOW);
	wire rd_high = i_rd && (i_addr == `OFF_RES_HIGH);
	wire conv_len_end; // Last converter clock of conversion
	wire [4:0] len = first_q ? `CYC_FIRST : `CYC_NORMAL;
	wire [4:0] samp = first_q ? `SAMPLE_FIRST : `SAMPLE_NORMAL;
	wire [4:0] bit_start = samp + 5'h01; // First bit decision clock
	wire done_evt; // Conversion finished this cycle
	wire [7:0] ctl_view;

	// Bit weight for the step index counted from the top
	function [9:0] weight;
		input [4:0] step;
		begin
			weight = 10'h200 >> step;
		end
	endfunction

	// Byte views of the result for both alignments
	function [7:0] res_byte;
		input [9:0] r;
		input left;
		input high;
		begin
			// Unused bits read as zero in either alignment
			if (left) begin
				res_byte = high ? r[9:2] : {r[1:0], 6'h00};
			end else begin
				res_byte = high ? {6'h00, r[9:8]} : r[7:0];
			end
		end
	endfunction

	// Prescaler runs only while enabled, so its phase restarts with each switch-on
	adc_prescaler u_prescaler (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_run(enable_q),
		.i_select(ps_q),
		.o_tick(tick)
	);

	// Length counted from the tick that leaves idle, so both ends land on ticks
	assign conv_len_end = (state_q == S_CONV) && tick && (cyc_q == len - 5'h01);
	assign done_evt = conv_len_end && enable_q;
	// Status view; bit order matches the control write layout
	assign ctl_view = {enable_q, start_q, free_q, flag_q, ie_q, ps_q};
	assign o_irq = flag_q && ie_q && i_global_int_enable;

	// Selection register, software side
	// Reserved bit is masked on write rather than on read
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			select_q <= `SELECT_RST;
		end else if (wr_sel) begin
			select_q <= i_wdata & `SEL_WMASK; // Bit 4 reads zero
		end
	end

	// Selection seen by the core; follows software only while not converting
	// Updating resumes on the last converter clock so the next conversion sees new picks
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_reference <= 2'h0;
			o_channel <= 4'h0;
		end else if (state_q != S_CONV || conv_len_end) begin
			o_reference <= select_q[`SEL_REF_HI:`SEL_REF_LO];
			o_channel <= select_q[`SEL_CH_HI:`SEL_CH_LO];
		end
	end

	// Control bits: enable, free running, interrupt enable, prescaler
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			enable_q <= 1'b0;
			free_q <= 1'b0;
			ie_q <= 1'b0;
			ps_q <= 3'h0;
		end else if (wr_ctl) begin
			enable_q <= i_wdata[`CTL_EN];
			free_q <= i_wdata[`CTL_FREE];
			ie_q <= i_wdata[`CTL_IE];
			ps_q <= i_wdata[`CTL_PS_HI:`CTL_PS_LO];
		end
	end

	// Flag: hardware set wins over a clear in the same cycle
	// Vector acknowledge and a one write are both clears, so their order is moot
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			flag_q <= 1'b0;
		end else if (done_evt) begin
			flag_q <= 1'b1;
		end else if (i_vector_ack) begin
			flag_q <= 1'b0;
		end else if (wr_ctl && i_wdata[`CTL_FLAG]) begin
			flag_q <= 1'b0;
		end
	end

	// Start bit: set by a one write, cleared at completion when not free running, or at abort
	// Disable beats a simultaneous start, so no start outlives power-down
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			start_q <= 1'b0;
		end else if (wr_ctl && !i_wdata[`CTL_EN]) begin
			start_q <= 1'b0;
		end else if (wr_ctl && i_wdata[`CTL_START]) begin
			start_q <= 1'b1;
		end else if (done_evt && !free_q) begin
			start_q <= 1'b0;
		end
	end

	// Initialising conversion pending after each switch-on
	// Any power-down makes the next conversion the long initialising one
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			first_q <= 1'b1;
		end else if (!enable_q) begin
			first_q <= 1'b1;
		end else if (done_evt) begin
			first_q <= 1'b0;
		end
	end

	// Conversion sequencer on converter clock ticks
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= S_IDLE;
			cyc_q <= 5'h00;
			sar_q <= 10'h000;
			o_sample <= 1'b0;
			o_trial <= 10'h000;
			o_power_on <= 1'b0;
		end else begin
			o_power_on <= enable_q;
			o_sample <= 1'b0;
			// Abort drops the state at once; result registers keep their last value
			if (!enable_q) begin
				state_q <= S_IDLE; // abort
				cyc_q <= 5'h00;
			end else begin
				case (state_q)
					S_IDLE: begin
						// Conversion begins on the next converter clock
						if (start_q && tick) begin
							state_q <= S_CONV;
							cyc_q <= 5'h00;
							sar_q <= 10'h000;
						end
					end
					S_CONV: begin
						if (tick) begin
							cyc_q <= cyc_q + 5'h01;
							// Trial word is registered, so its answer is read a tick later
							if (cyc_q == samp) begin
								o_sample <= 1'b1;
								o_trial <= weight(5'h00);
							end else if (cyc_q >= bit_start &&
								cyc_q < bit_start + `SAR_STEPS) begin
								// Keep or drop trial bit, then try the next one
								sar_q <= (i_compare ? o_trial : sar_q)
									| 10'h000;
								o_trial <= (i_compare ? o_trial : sar_q)
									| weight(cyc_q - bit_start + 5'h01);
							end
							if (conv_len_end) begin
								state_q <= S_DONE;
							end
						end
					end
					S_DONE: begin
						// Free running restarts at once; single waits for start
						if (free_q && start_q) begin
							state_q <= S_CONV;
							cyc_q <= 5'h00;
							sar_q <= 10'h000;
							o_trial <= 10'h000;
						end else begin
							state_q <= S_IDLE;
						end
					end
					default: state_q <= S_IDLE;
				endcase
			end
		end
	end

	// Result capture with low/high read lock
	// A low read in the completion cycle also holds the new result back
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			result_q <= 10'h000;
			pending_q <= 10'h000;
			pend_valid_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			if (rd_low) begin
				lock_q <= 1'b1;
			end else if (rd_high) begin
				lock_q <= 1'b0;
			end
			if (done_evt) begin
				if ((lock_q || rd_low) && !rd_high) begin
					pending_q <= sar_q;
					pend_valid_q <= 1'b1;
				end else begin
					result_q <= sar_q & `RES_TOP;
					pend_valid_q <= 1'b0;
				end
			end else if (pend_valid_q && !lock_q) begin
				result_q <= pending_q;
				pend_valid_q <= 1'b0;
			end
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	// Alignment is applied at read time, so a left-adjust change shows at once
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			case (i_addr)
				`OFF_SELECT: o_rdata <= select_q;
				`OFF_CONTROL: o_rdata <= ctl_view;
				`OFF_RES_LOW: o_rdata <= res_byte(result_q, select_q[`SEL_LEFT], 1'b0);
				`OFF_RES_HIGH: o_rdata <= res_byte(result_q, select_q[`SEL_LEFT], 1'b1);
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end
endmodule

// [testbench/adc_conversion_control_chk.sv]
// Purpose: Port checks for the converter control block
// Assumes: One clock, synchronous reset
// Notes: Bound into the design at the foot
`timescale 1ns/1ns
module adc_ctl_chk (
	input wire i_clk,
	input wire i_sys_rst,
	input wire [1:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [7:0] o_rdata,
	input wire i_global_int_enable,
	input wire o_irq,
	input wire o_power_on,
	input wire [1:0] o_reference,
	input wire [3:0] o_channel,
	input wire o_sample,
	input wire [9:0] o_trial
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Write, idle cycle, read of the same place
	sequence wr_then_rd(a);
		i_wr && i_addr == a ##2 i_rd && i_addr == a;
	endsequence
	AST_RDATA_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	AST_SEL_READBACK: assert property (wr_then_rd(2'h0) |=> o_rdata == ($past(i_wdata, 3) & 8'hEF))
		else $error("select readback wrong");
	AST_CTL_READBACK: assert property (wr_then_rd(2'h1) |=> o_rdata[3:0] == $past(i_wdata[3:0], 3))
		else $error("control readback wrong");
	AST_POWER: assert property (i_wr && i_addr == 2'h1 |=> ##1 o_power_on == $past(i_wdata[7], 2))
		else $error("power does not follow enable");
	AST_IRQ_GATE: assert property (o_irq |-> i_global_int_enable)
		else $error("interrupt without global enable");
	AST_SEL_FROZEN: assert property (o_sample |=> ($stable(o_channel) && $stable(o_reference))[*8])
		else $error("selection moved during conversion");
	AST_SAMPLE_GAP: assert property (o_sample |=> (!o_sample)[*8])
		else $error("sample strobes too close");
	AST_NO_SAMPLE_OFF: assert property (!o_power_on |-> !o_sample)
		else $error("sample while powered off");
	AST_TRIAL_TOP: assert property (o_sample |-> o_trial == 10'h200)
		else $error("first trial is not the top bit");
endmodule
bind adc_conversion_control adc_ctl_chk adc_ctl_chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_global_int_enable(i_global_int_enable), .o_irq(o_irq), .o_power_on(o_power_on),
	.o_reference(o_reference), .o_channel(o_channel), .o_sample(o_sample),
	.o_trial(o_trial));

// [testbench/adc_core_model.sv]
// Purpose: Behavioural analog core with input multiplexer
// Assumes: Comparator answers in the same cycle
// Notes: Reference choice does not scale the code here
`timescale 1ns/1ns
module adc_core_model (
	input wire i_clk,
	input wire [3:0] i_channel,
	input wire i_sample,
	input wire [9:0] i_trial,
	output wire o_compare
);
	reg [9:0] held_q = 10'h000; // Held input code, kept still through a conversion
	// Ground reads zero, inputs give a channel-dependent code
	always @(posedge i_clk) begin
		if (i_sample) begin
			held_q <= (i_channel == 4'hF) ? 10'h000 : {i_channel, 6'h15};
		end
	end
	assign o_compare = (held_q >= i_trial);
endmodule

// [testbench/tb.sv]
// Purpose: Self-checking bench for converter control
// Assumes: Divide-by-two converter clock in conversions
// Notes: Polls bounded; a timeout ends the run
`timescale 1ns/1ns
module tb;
	localparam [9:0] CODE = 10'h0D5; // Model code for channel 3
	reg i_clk = 1'b0;
	reg i_sys_rst = 1'b1;
	reg [1:0] i_addr = 2'h0;
	reg [7:0] i_wdata = 8'h00;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	reg i_global_int_enable = 1'b0;
	reg i_vector_ack = 1'b0;
	wire [7:0] o_rdata;
	wire i_compare, o_irq, o_power_on, o_sample;
	wire [1:0] o_reference;
	wire [3:0] o_channel;
	wire [9:0] o_trial;
	integer err_total = 0, tests_run = 0, cyc = 0, t0, i;
	reg [7:0] d;
	reg [17:0] rows [0:6]; // Place, write data, expected read
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk) cyc <= cyc + 1;
	adc_conversion_control adc_conversion_control_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_global_int_enable(i_global_int_enable), .i_vector_ack(i_vector_ack),
		.i_compare(i_compare), .o_irq(o_irq), .o_power_on(o_power_on),
		.o_reference(o_reference), .o_channel(o_channel), .o_sample(o_sample), .o_trial(o_trial));
	adc_core_model adc_core_model_i (.i_clk(i_clk), .i_channel(o_channel), .i_sample(o_sample),
		.i_trial(o_trial), .o_compare(i_compare));
	task end_of_test;
		begin
			$display("errors %0d checks %0d", err_total, tests_run);
			if (err_total == 0 && tests_run > 0) begin
				$display("DONE - PASS");
			end else begin
				$display("DONE - FAIL");
			end
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [7:0] exp, input [7:0] got);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task wr(input [1:0] a, input [7:0] v);
		begin
			@(posedge i_clk);
			i_wr <= 1'b1;
			i_addr <= a;
			i_wdata <= v;
			@(posedge i_clk);
			i_wr <= 1'b0;
		end
	endtask
	// Data stands only in the cycle after the strobe
	task rd(input [1:0] a);
		begin
			@(posedge i_clk);
			i_rd <= 1'b1;
			i_addr <= a;
			@(posedge i_clk);
			i_rd <= 1'b0;
			#1 d = o_rdata;
		end
	endtask
	// Bounded poll of the control register
	task poll(input [7:0] m, input [7:0] v);
		integer n;
		begin
			d = ~v;
			for (n = 0; n < 200 && (d & m) !== v; n = n + 1) rd(2'h1);
			if ((d & m) !== v) begin
				err_total = err_total + 1;
				end_of_test;
			end
		end
	endtask
	initial begin
		rows[0] = {2'h0, 8'hFF, 8'hEF};
		rows[1] = {2'h0, 8'h10, 8'h00};
		rows[2] = {2'h0, 8'h6A, 8'h6A};
		rows[3] = {2'h1, 8'h2F, 8'h2F};
		rows[4] = {2'h1, 8'h00, 8'h00};
		rows[5] = {2'h2, 8'hFF, 8'h00};
		rows[6] = {2'h3, 8'hFF, 8'h00};
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			rd(i[1:0]);
			chk("reset", 8'h00, d);
		end
		for (i = 0; i < 7; i = i + 1) begin
			wr(rows[i][17:16], rows[i][15:8]);
			rd(rows[i][17:16]);
			chk("row", rows[i][7:0], d);
		end
		// First conversion is the long one
		@(posedge i_clk) i_global_int_enable <= 1'b1;
		wr(2'h0, 8'h43);
		t0 = cyc;
		wr(2'h1, 8'hC8);
		poll(8'h50, 8'h10);
		chk("first", 8'h01, {7'h00, (cyc - t0 >= 50 && cyc - t0 <= 60)});
		chk("irq", 8'h01, {7'h00, o_irq});
		rd(2'h2);
		chk("low", CODE[7:0], d);
		rd(2'h3);
		chk("high", {6'h00, CODE[9:8]}, d);
		wr(2'h0, 8'h63);
		rd(2'h2);
		chk("left lo", {CODE[1:0], 6'h00}, d);
		rd(2'h3);
		chk("left hi", CODE[9:2], d);
		@(posedge i_clk) i_vector_ack <= 1'b1;
		@(posedge i_clk) i_vector_ack <= 1'b0;
		rd(2'h1);
		chk("ack", 8'h00, {d[4], 6'h00, o_irq});
		chk("route", 8'h13, {2'h0, o_reference, o_channel});
		// Second conversion, ground input, short length; new pick written right after the start write
		wr(2'h0, 8'h4F);
		t0 = cyc;
		wr(2'h1, 8'hC8);
		wr(2'h0, 8'hE3);
		#1 chk("frozen", 8'h1F, {2'h0, o_reference, o_channel});
		poll(8'h50, 8'h10);
		chk("second", 8'h01, {7'h00, (cyc - t0 >= 26 && cyc - t0 <= 36)});
		chk("unlock", 8'h33, {2'h0, o_reference, o_channel});
		rd(2'h2);
		chk("gnd", 8'h00, d);
		wr(2'h1, 8'h88);
		rd(2'h1);
		chk("w0 flag", 8'h10, d & 8'h50);
		wr(2'h1, 8'h98);
		rd(2'h1);
		chk("w1 flag", 8'h00, d & 8'h10);
		// Free running keeps converting without new starts
		wr(2'h1, 8'hE8);
		poll(8'h10, 8'h10);
		wr(2'h1, 8'hB8);
		poll(8'h10, 8'h10);
		chk("free", 8'h40, d & 8'h40);
		// The low read of the ground result locked it against the free run
		rd(2'h3);
		chk("held hi", 8'h00, d);
		rd(2'h2);
		chk("new lo", {CODE[1:0], 6'h00}, d);
		wr(2'h1, 8'h00);
		rd(2'h1);
		chk("off", 8'h00, {d[7:6], 5'h00, o_power_on});
		end_of_test;
	end
endmodule
